/* design/ebm_defs.svh */
// Contract
// [RULE1] normal mode: output shows stored data on reads only, never during writes
// [RULE2] write-through mode: written data is copied to the same port's output
// [RULE3] read-before-write mode: a write shows old location contents on output
// [RULE4] each block works as RAM, ROM or FIFO with dedicated pointer/flag logic
// [RULE5] FIFO write taken on write clock enable plus write enable
// [RULE6] FIFO read port independent, taken on read clock enable plus read enable
// [RULE7] full and almost-full flags are registers of the write side
// [RULE8] empty and almost-empty flags are registers of the read side
// [RULE9] full 1..2^N-1, almost levels 1..full-1, empty fixed at zero
// [RULE10] FIFO reset clears both pointers and returns all four flags to reset state
// [RULE11] read-pointer reset rewinds only the read pointer for retransmission
// [RULE12] user logic tracks packet boundaries before using read-pointer rewind
// [RULE13] full input pin acts as bit 2 of write port select
// [RULE14] empty input pin acts as bit 2 of read port select
// [RULE15] output read enable gates the registered FIFO read data output
// [RULE16] dual-port mode offers two full ports A and B
// [RULE17] FIFO provides full, almost full, empty and almost empty outputs
// [RULE18] per-port output reset clears that port; global reset clears both
// [RULE19] writes ignored while full, reads ignored while empty
// [RULE20] pointers cross sides Gray coded through two-flop synchronisers
`ifndef EBM_DEFS_SVH
`define EBM_DEFS_SVH

`define EBM_AW 10
`define EBM_PW 11
`define EBM_DW 9
`define EBM_DEPTH 1024
`define EBM_RAM_CS_CODE 3'h0
`define EBM_FIFO_CS_CODE 3'h0
`define EBM_EMPTY_LEVEL 11'h000
`define EBM_LEVEL_MIN 10'h001
`define EBM_LEVEL_MAX 10'h3FF

`endif

/* design/ebm_pkg.sv */
`include "ebm_defs.svh"

package ebm_pkg;

	// memory operating forms
	typedef enum logic [1:0] {
		EBM_MODE_SINGLE,
		EBM_MODE_DUAL,
		EBM_MODE_ROM,
		EBM_MODE_FIFO
	} ebm_mode_e;

	// per-port write behaviour
	typedef enum logic [1:0] {
		EBM_WM_NORMAL,
		EBM_WM_THROUGH,
		EBM_WM_RBW
	} ebm_wmode_e;

	// one RAM port request bundle
	typedef struct packed {
		logic ce;
		logic [2:0] cs;
		logic we;
		logic output_register_clock_enable;
		logic rst;
		logic [`EBM_AW-1:0] addr;
		logic [`EBM_DW-1:0] data;
	} ebm_port_s;

	// all flip-flop state of the block except the memory array
	typedef struct packed {
		logic [1:0][`EBM_DW-1:0] core;
		logic [1:0][`EBM_DW-1:0] dout;
		logic [`EBM_PW-1:0] wptr;
		logic [`EBM_PW-1:0] rptr;
		logic [`EBM_PW-1:0] wgray;
		logic [`EBM_PW-1:0] rgray;
		logic [`EBM_PW-1:0] wg_s1;
		logic [`EBM_PW-1:0] wg_s2;
		logic [`EBM_PW-1:0] rg_s1;
		logic [`EBM_PW-1:0] rg_s2;
		logic [`EBM_DW-1:0] frd;
		logic [`EBM_DW-1:0] fout;
		logic full;
		logic afull;
		logic empty;
		logic aempty;
	} ebm_state_s;

	localparam ebm_state_s EBM_STATE_INIT = '{empty: 1'b1, aempty: 1'b1, default: '0};

endpackage

/* design/ebm_top.sv */
`timescale 1ns/1ps
`include "ebm_defs.svh"

module ebm_top
	import ebm_pkg::*;
(
	// clock and global reset
	input wire logic i_mclk,
	input wire logic i_reset_n,
	// configuration
	input wire ebm_mode_e i_mode,
	input wire ebm_wmode_e i_write_mode_a,
	input wire ebm_wmode_e i_write_mode_b,
	// RAM ports
	input wire ebm_port_s i_port_a,
	input wire ebm_port_s i_port_b,
	output logic [`EBM_DW-1:0] o_a_data,
	output logic [`EBM_DW-1:0] o_b_data,
	// FIFO write side
	input wire logic i_fifo_reset,
	input wire logic i_write_clock_enable,
	input wire logic i_write_enable,
	input wire logic [1:0] i_write_port_select,
	input wire logic i_full_input_pin,
	input wire logic [`EBM_DW-1:0] i_fifo_data,
	// FIFO read side
	input wire logic i_read_clock_enable,
	input wire logic i_read_enable,
	input wire logic [1:0] i_read_port_select,
	input wire logic i_empty_input_pin,
	input wire logic i_output_read_enable,
	input wire logic i_read_pointer_reset,
	output logic [`EBM_DW-1:0] o_fifo_data,
	// flag thresholds
	input wire logic [`EBM_AW-1:0] i_full_level,
	input wire logic [`EBM_AW-1:0] i_almost_full_level,
	input wire logic [`EBM_AW-1:0] i_almost_empty_level,
	// FIFO status
	output logic o_full_flag,
	output logic o_almost_full_flag,
	output logic o_empty_flag,
	output logic o_almost_empty_flag
);

	ebm_state_s s;
	ebm_state_s next_s;
	logic [`EBM_DW-1:0] mem [`EBM_DEPTH];
	logic [1:0] mem_we;
	logic [1:0][`EBM_AW-1:0] mem_wa;
	logic [1:0][`EBM_DW-1:0] mem_wd;
	logic [`EBM_AW-1:0] full_lvl;
	logic [`EBM_AW-1:0] af_lvl;
	logic [`EBM_AW-1:0] ae_lvl;

	function automatic logic [`EBM_PW-1:0] bin2gray(input logic [`EBM_PW-1:0] b);
		return b ^ (b >> 1);
	endfunction

	function automatic logic [`EBM_PW-1:0] gray2bin(input logic [`EBM_PW-1:0] g);
		logic [`EBM_PW-1:0] b;
		b[`EBM_PW-1] = g[`EBM_PW-1];
		for (int i = `EBM_PW - 2; i >= 0; i--) begin
			b[i] = b[i+1] ^ g[i];
		end
		return b;
	endfunction

	// keeps a level inside lo..hi; hi below lo collapses to lo
	function automatic logic [`EBM_AW-1:0] clamp(input logic [`EBM_AW-1:0] v,
			input logic [`EBM_AW-1:0] lo, input logic [`EBM_AW-1:0] hi);
		logic [`EBM_AW-1:0] r;
		r = (v < lo) ? lo : v;
		r = (r > hi) ? hi : r;
		return (r < lo) ? lo : r;
	endfunction

	// threshold ranges; out-of-range settings are pulled to the nearest legal value
	always_comb begin
		full_lvl = clamp(i_full_level, `EBM_LEVEL_MIN, `EBM_LEVEL_MAX); // RULE9
		af_lvl = clamp(i_almost_full_level, `EBM_LEVEL_MIN, full_lvl - `EBM_LEVEL_MIN); // RULE9
		ae_lvl = clamp(i_almost_empty_level, `EBM_LEVEL_MIN, full_lvl - `EBM_LEVEL_MIN); // RULE9
	end

	// next-state logic for RAM ports, FIFO write side and FIFO read side
	always_comb begin
		ebm_port_s req;
		ebm_wmode_e wm;
		logic fifo;
		logic active;
		logic wr;
		logic wr_ok;
		logic rd_ok;
		logic [`EBM_PW-1:0] wcnt;
		logic [`EBM_PW-1:0] rcnt;
		req = i_port_a;
		wm = i_write_mode_a;
		fifo = 1'b0;
		active = 1'b0;
		wr = 1'b0;
		wr_ok = 1'b0;
		rd_ok = 1'b0;
		wcnt = '0;
		rcnt = '0;
		next_s = s;
		mem_we = '0;
		mem_wa = '0;
		mem_wd = '0;
		fifo = (i_mode == EBM_MODE_FIFO); // RULE4

		// RAM/ROM ports; port B only reads and writes the array in dual-port form, its reset and output register work in every form
		for (int p = 0; p < 2; p++) begin
			req = (p == 0) ? i_port_a : i_port_b;
			wm = (p == 0) ? i_write_mode_a : i_write_mode_b;
			active = !fifo && (p == 0 || i_mode == EBM_MODE_DUAL) && req.ce &&
				(req.cs == `EBM_RAM_CS_CODE); // RULE16
			wr = active && req.we && (i_mode != EBM_MODE_ROM); // RULE4
			if (req.rst) begin
				next_s.core[p] = '0; // RULE18
				next_s.dout[p] = '0; // RULE18
			end else begin
				if (active && !wr) begin
					next_s.core[p] = mem[req.addr]; // RULE1
				end else if (wr) begin
					case (wm)
						EBM_WM_NORMAL: next_s.core[p] = s.core[p]; // RULE1
						EBM_WM_THROUGH: next_s.core[p] = req.data; // RULE2
						EBM_WM_RBW: next_s.core[p] = mem[req.addr]; // RULE3
						default: next_s.core[p] = s.core[p];
					endcase
				end
				if (req.output_register_clock_enable) begin
					next_s.dout[p] = s.core[p];
				end
			end
			mem_we[p] = wr;
			mem_wa[p] = req.addr;
			mem_wd[p] = req.data;
		end

		// FIFO write side; full input pin stands in for select bit 2
		wr_ok = fifo && i_write_clock_enable && i_write_enable && !s.full && // RULE5 RULE19
			({i_full_input_pin, i_write_port_select} == `EBM_FIFO_CS_CODE); // RULE13
		if (wr_ok) begin
			mem_we[0] = 1'b1;
			mem_wa[0] = s.wptr[`EBM_AW-1:0];
			mem_wd[0] = i_fifo_data;
			next_s.wptr = s.wptr + `EBM_PW'(1);
		end
		next_s.rg_s1 = s.rgray; // RULE20
		next_s.rg_s2 = s.rg_s1; // RULE20
		wcnt = next_s.wptr - gray2bin(s.rg_s2); // RULE20
		next_s.full = (wcnt >= {1'b0, full_lvl}); // RULE7
		next_s.afull = (wcnt >= {1'b0, af_lvl}); // RULE7

		// FIFO read side; a rewind beats a read in the same cycle
		rd_ok = fifo && i_read_clock_enable && i_read_enable && !s.empty && // RULE6 RULE19
			({i_empty_input_pin, i_read_port_select} == `EBM_FIFO_CS_CODE); // RULE14
		if (rd_ok) begin
			next_s.frd = mem[s.rptr[`EBM_AW-1:0]];
			next_s.rptr = s.rptr + `EBM_PW'(1);
		end
		if (i_read_pointer_reset) begin
			next_s.rptr = '0; // RULE11
		end
		if (i_output_read_enable) begin
			next_s.fout = s.frd; // RULE15
		end
		next_s.wg_s1 = s.wgray; // RULE20
		next_s.wg_s2 = s.wg_s1; // RULE20
		rcnt = gray2bin(s.wg_s2) - next_s.rptr; // RULE20
		next_s.empty = (rcnt == `EBM_EMPTY_LEVEL); // RULE8 RULE9
		next_s.aempty = (rcnt <= {1'b0, ae_lvl}); // RULE8

		// gray copies registered straight from binary so no glitchy code crosses
		next_s.wgray = bin2gray(next_s.wptr); // RULE20
		next_s.rgray = bin2gray(next_s.rptr); // RULE20

		// FIFO reset wins over everything on the pointer side
		if (i_fifo_reset) begin
			next_s.wptr = '0; // RULE10
			next_s.rptr = '0; // RULE10
			next_s.wgray = '0;
			next_s.rgray = '0;
			next_s.wg_s1 = '0;
			next_s.wg_s2 = '0;
			next_s.rg_s1 = '0;
			next_s.rg_s2 = '0;
			next_s.frd = '0;
			next_s.fout = '0;
			next_s.full = 1'b0; // RULE10
			next_s.afull = 1'b0; // RULE10
			next_s.empty = 1'b1; // RULE10
			next_s.aempty = 1'b1; // RULE10
		end
	end

	// single state register; global reset clears both ports and the FIFO
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			s <= EBM_STATE_INIT; // RULE18
		end else begin
			s <= next_s;
		end
	end

	// memory array, no reset; port B wins a same-address collision
	always_ff @(posedge i_mclk) begin
		for (int p = 0; p < 2; p++) begin
			if (mem_we[p]) begin
				mem[mem_wa[p]] <= mem_wd[p];
			end
		end
	end

	// outputs straight from the state register
	assign o_a_data = s.dout[0];
	assign o_b_data = s.dout[1];
	assign o_fifo_data = s.fout;
	assign o_full_flag = s.full; // RULE17
	assign o_almost_full_flag = s.afull; // RULE17
	assign o_empty_flag = s.empty; // RULE17
	assign o_almost_empty_flag = s.aempty; // RULE17

endmodule

/* dv/ebm_user.sv */
`timescale 1ns/1ps

// write-side user logic: turns a push request into the write qualifiers
module ebm_user (
	// request from the test sequence
	input wire logic i_mclk,
	input wire logic i_push,
	input wire logic [8:0] i_word,
	// fifo write port
	output logic o_wce,
	output logic o_we,
	output logic [8:0] o_data
);
	// both qualifiers move together; idle data is inverted so no stale word looks valid
	assign o_wce = i_push;
	assign o_we = i_push;
	assign o_data = i_push ? i_word : ~i_word;
endmodule

/* dv/ebm_chk.sv */
`timescale 1ns/1ps
`include "ebm_defs.svh"

module ebm_chk
	import ebm_pkg::*;
(
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_reset_n,
	// watched inputs
	input wire ebm_port_s i_port_a,
	input wire logic i_fifo_reset,
	input wire logic i_write_clock_enable,
	input wire logic i_write_enable,
	input wire logic [1:0] i_write_port_select,
	input wire logic i_full_input_pin,
	input wire logic i_output_read_enable,
	// watched outputs
	input wire logic [`EBM_DW-1:0] o_a_data,
	input wire logic [`EBM_DW-1:0] o_fifo_data,
	input wire logic o_full_flag,
	input wire logic o_almost_full_flag,
	input wire logic o_empty_flag,
	input wire logic o_almost_empty_flag
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_reset_n);

	a_reset_flags: assert property (i_fifo_reset |=> o_empty_flag && o_almost_empty_flag
		&& !o_full_flag && !o_almost_full_flag) else $error("flags wrong after fifo reset");
	a_reset_data: assert property (i_fifo_reset |=> o_fifo_data == '0)
		else $error("fifo data not cleared");
	a_full_has_af: assert property (o_full_flag |-> o_almost_full_flag)
		else $error("full without almost full");
	a_empty_has_ae: assert property (o_empty_flag |-> o_almost_empty_flag)
		else $error("empty without almost empty");
	a_port_clear: assert property (i_port_a.rst |-> ##2 o_a_data == '0)
		else $error("port output not cleared");
	a_ore_hold: assert property (!i_output_read_enable && !i_fifo_reset |=> $stable(o_fifo_data))
		else $error("fifo data moved without read enable");
	a_oce_hold: assert property (!i_port_a.output_register_clock_enable && !i_port_a.rst |=> $stable(o_a_data))
		else $error("port data moved without output enable");
	a_write_fills: assert property (i_write_clock_enable && i_write_enable && !i_full_input_pin
		&& i_write_port_select == 2'h0 && !i_fifo_reset ##1 !i_fifo_reset [*6]
		|-> !o_empty_flag) else $error("accepted write never seen by read side");

	c_full: cover property (o_full_flag);
	c_ore: cover property (i_output_read_enable);
	c_port_rst: cover property (i_port_a.rst);
endmodule

bind ebm_top ebm_chk i_chk (.*);

/* dv/tb_top.sv */
`timescale 1ns/1ps

module tb_top;
	import ebm_pkg::*;
	logic i_mclk = 0, i_reset_n = 0, i_fifo_reset = 0, i_write_clock_enable, i_write_enable;
	ebm_mode_e i_mode = EBM_MODE_FIFO;
	ebm_wmode_e i_write_mode_a = EBM_WM_NORMAL, i_write_mode_b = EBM_WM_NORMAL;
	ebm_port_s i_port_a = '0, i_port_b = '0;
	logic [1:0] i_write_port_select = '0, i_read_port_select = '0;
	logic i_full_input_pin = 0, i_read_clock_enable = 0, i_read_enable = 0, i_empty_input_pin = 0;
	logic i_output_read_enable = 0, i_read_pointer_reset = 0, push = 0;
	logic [9:0] i_full_level = 10'h004, i_almost_full_level = 10'h003;
	logic [9:0] i_almost_empty_level = 10'h001;
	logic [8:0] i_fifo_data, word = '0, o_a_data, o_b_data, o_fifo_data;
	logic o_full_flag, o_almost_full_flag, o_empty_flag, o_almost_empty_flag;
	int mismatches = 0, num_checks = 0;

	// 40 MHz clock
	always #12.5 i_mclk = ~i_mclk;

	ebm_top i_dut (.*);
	ebm_user i_user (.i_mclk(i_mclk), .i_push(push), .i_word(word),
		.o_wce(i_write_clock_enable), .o_we(i_write_enable), .o_data(i_fifo_data));

	task tick(input int n);
		repeat (n) @(negedge i_mclk);
	endtask
	task chk(input logic [8:0] got, input logic [8:0] exp);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task flags(input logic [3:0] exp);
		chk({5'h00, o_full_flag, o_almost_full_flag, o_empty_flag, o_almost_empty_flag}, {5'h00, exp});
	endtask
	// caller drops push, so back-to-back writes never toggle it in one step
	task fw(input logic [8:0] d);
		push = 1;
		word = d;
		tick(1);
	endtask
	// read edge loads the read register, next edge the output register, then one spare edge
	task fr(input logic [8:0] exp);
		i_read_clock_enable = 1;
		i_read_enable = 1;
		i_output_read_enable = 1;
		tick(1);
		i_read_clock_enable = 0;
		i_read_enable = 0;
		tick(2);
		chk(o_fifo_data, exp);
		// one idle edge so the next read never raises the enable in this same step
		i_output_read_enable = 0;
		tick(1);
	endtask
	task ram(input logic w, input logic [9:0] a, input logic [8:0] d);
		i_port_a.ce = 1;
		i_port_a.we = w;
		i_port_a.addr = a;
		i_port_a.data = d;
		tick(1);
		i_port_a.ce = 0;
		tick(2);
	endtask
	task end_of_test;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	// test sequence
	initial begin
		tick(5);
		i_reset_n = 1;
		flags(4'h3);
		for (int i = 0; i < 5; i++) fw(9'h101 + 9'(i));
		push = 0;
		tick(6);
		flags(4'hC);
		for (int i = 0; i < 4; i++) fr(9'h101 + 9'(i));
		tick(6);
		flags(4'h3);
		fr(9'h104);
		// the packet of four words is known to sit at the start
		i_read_pointer_reset = 1;
		tick(1);
		i_read_pointer_reset = 0;
		tick(6);
		fr(9'h101);
		fr(9'h102);
		$display("fifo test done");
		i_fifo_reset = 1;
		tick(1);
		i_fifo_reset = 0;
		tick(1);
		flags(4'h3);
		chk(o_fifo_data, 9'h000);
		i_full_input_pin = 1;
		fw(9'h055);
		push = 0;
		i_full_input_pin = 0;
		tick(6);
		flags(4'h3);
		fw(9'h066);
		push = 0;
		tick(6);
		i_empty_input_pin = 1;
		fr(9'h000);
		i_empty_input_pin = 0;
		fr(9'h066);
		$display("select test done");
		i_mode = EBM_MODE_SINGLE;
		i_port_a.output_register_clock_enable = 1;
		for (int m = 0; m < 3; m++) begin
			i_write_mode_a = ebm_wmode_e'(m);
			ram(1, 10'h005, 9'h010 + 9'(m));
			ram(1, 10'h006, 9'h0AA);
			ram(0, 10'h006, 9'h000);
			ram(1, 10'h005, 9'h1F0);
			chk(o_a_data, m == 0 ? 9'h0AA : m == 1 ? 9'h1F0 : 9'h012);
		end
		i_mode = EBM_MODE_ROM;
		ram(1, 10'h005, 9'h033);
		ram(0, 10'h005, 9'h000);
		chk(o_a_data, 9'h1F0);
		i_mode = EBM_MODE_DUAL;
		i_port_b.output_register_clock_enable = 1;
		i_port_b.addr = 10'h006;
		i_port_b.ce = 1;
		tick(1);
		i_port_b.ce = 0;
		tick(2);
		chk(o_b_data, 9'h0AA);
		i_port_a.rst = 1;
		tick(1);
		i_port_a.rst = 0;
		tick(1);
		chk(o_a_data, 9'h000);
		chk(o_b_data, 9'h0AA);
		$display("ram test done");
		end_of_test;
	end

	// watchdog well past the 128 cycles the tests need
	initial begin
		tick(3000);
		mismatches++;
		end_of_test;
	end
endmodule
